// file: lbr_ctrl.sv
// Purpose: memory bus to block RAM controller with optional ECC
// Assumes: bus masters share one clock with the controller
// Notes: one cycle read latency, registers on a plain port
// Contract
// - Each port decodes only address bits selected by its own mask.
// - Number of bus ports is a parameter; all see the same RAM.
// - Address and data buses are exactly 32 bits.
// - Window is a power of two bytes with aligned base.
// - With ECC, single errors are corrected, double errors flagged.
// - Fault injection registers corrupt stored data or check bits.
// - First correctable error address captured, held until its status bit is cleared.
// - First uncorrectable error address captured separately.
// - Status readable; control decides whether check bits are generated or written as zero.
// - On/off register switches checking at run time.
// - On/off register resets to a configured value.
// - Correctable error counter of configured width; zero omits it.
// - Write access configurable as full, word-only or none.
// - ECC registers reachable only with a register port configured.
// - Write setting 0 none, 1 word only, 2 all widths.
// - All storage runs on the single bus clock.
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module lbr_ctrl
	import lbr_pkg::*;
#(
	parameter int unsigned NUM_PORTS = 1,
	parameter logic [31:0] WINDOW_BASE = LBR_BASE_RST,
	parameter logic [31:0] WINDOW_TOP = LBR_TOP_RST,
	parameter logic [31:0] DECODE_MASK [NUM_PORTS] = '{default: LBR_MASK_RST},
	parameter int unsigned ECC_EN = 0,
	parameter int unsigned REG_PORT_EN = 0,
	parameter int unsigned FAULT_INJECT = 0,
	parameter int unsigned CE_CAPTURE = 0,
	parameter int unsigned UE_CAPTURE = 0,
	parameter int unsigned STATUS_EN = 0,
	parameter int unsigned ONOFF_EN = 0,
	parameter logic CHECK_ENABLE_RESET_VALUE = 1'b1,
	parameter int unsigned CE_COUNTER_WIDTH = 0,
	parameter logic [1:0] WRITE_ACCESS = LBR_WR_FULL,
	parameter int unsigned DEPTH_LOG2 = 11
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Memory bus ports
	input wire lbr_pkg::lbr_req_t bus_req [NUM_PORTS],
	output lbr_pkg::lbr_rsp_t bus_rsp [NUM_PORTS],
	// Register port
	input wire lbr_pkg::lbr_reg_t reg_req,
	output logic [31:0] reg_rdata
);
	import lbr_pkg::*;

	localparam int unsigned PW = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;
	localparam int unsigned CNW = (CE_COUNTER_WIDTH > 0) ? CE_COUNTER_WIDTH : 1;
	localparam logic HAS_REGS = (ECC_EN != 0) && (REG_PORT_EN != 0);

	// Port decode: masked compare, base aligned to the window size
	function automatic logic hit(input logic [31:0] a, input logic [31:0] m);
		return ((a & m) == (WINDOW_BASE & m));
	endfunction

	logic [NUM_PORTS-1:0] sel;
	logic [PW-1:0] win_idx;
	logic win_any;
	lbr_req_t win;
	logic [3:0] be_ok;
	logic wr_ok;

	// Port arbitration, lowest index wins
	always_comb begin
		sel = '0;
		win_idx = '0;
		win_any = 1'b0;
		for (int p = NUM_PORTS - 1; p >= 0; p--) begin
			sel[p] = bus_req[p].addr_strobe && hit(bus_req[p].addr,
				DECODE_MASK[p]);
			if (sel[p]) begin
				win_idx = PW'(p);
				win_any = 1'b1;
			end
		end
		win = bus_req[win_idx];
	end

	// Write permission filter
	always_comb begin
		unique case (WRITE_ACCESS)
			LBR_WR_NONE: wr_ok = 1'b0;
			LBR_WR_WORD: wr_ok = (win.be == 4'hF);
			default: wr_ok = 1'b1;
		endcase
		be_ok = (win_any && win.write_strobe && wr_ok) ? win.be : 4'h0;
	end

	// Control registers
	logic onoff_q;
	logic [31:0] ctrl_q;
	logic [31:0] inj_data_q;
	logic [LBR_CW-1:0] inj_chk_q;
	logic chk_on;
	logic gen_on;
	assign chk_on = (ECC_EN != 0) && ((ONOFF_EN == 0) || onoff_q);
	assign gen_on = (STATUS_EN == 0) || ctrl_q[LBR_CT_GEN];

	// Read-modify-write for partial writes under ECC
	logic [LBR_DW-1:0] wr_data;
	logic [LBR_CW-1:0] enc_chk;
	logic [LBR_RW-1:0] ram_wdata;
	logic [LBR_RW-1:0] ram_wmask;
	logic [LBR_RW-1:0] ram_rdata;
	logic [DEPTH_LOG2-1:0] ram_addr;
	logic ram_en;
	logic [LBR_DW-1:0] fixed;
	logic dec_ce;
	logic dec_ue;

	// Full words encoded directly; partial ones use the old word
	logic rmw_q;
	logic [3:0] rmw_be_q;
	logic [LBR_DW-1:0] rmw_data_q;
	logic [DEPTH_LOG2-1:0] rmw_addr_q;
	logic [PW-1:0] rmw_port_q;
	logic partial;
	assign partial = (ECC_EN != 0) && (be_ok != 4'h0) && (be_ok != 4'hF);

	always_comb begin
		wr_data = win.wdata;
		for (int b = 0; b < 4; b++) begin
			if (rmw_q && !rmw_be_q[b]) begin
				wr_data[b*8 +: 8] = fixed[b*8 +: 8];
			end else if (rmw_q) begin
				wr_data[b*8 +: 8] = rmw_data_q[b*8 +: 8];
			end
		end
	end

	lbr_ecc u_ecc (
		.enc_data(wr_data),
		.enc_chk(enc_chk),
		.dec_data(ram_rdata[LBR_DW-1:0]),
		.dec_chk(ram_rdata[LBR_RW-1:LBR_DW]),
		.dec_fixed(fixed),
		.dec_ce(dec_ce),
		.dec_ue(dec_ue)
	);

	// RAM port steering, with fault injection on writes
	always_comb begin
		ram_en = win_any || rmw_q;
		ram_addr = rmw_q ? rmw_addr_q : win.addr[DEPTH_LOG2+1:2];
		ram_wdata = {(gen_on ? enc_chk : LBR_CW'(0)) ^ inj_chk_q,
			wr_data ^ inj_data_q};
		ram_wmask = '0;
		if (rmw_q) begin
			ram_wmask = '1;
		end else if (!partial) begin
			for (int b = 0; b < 4; b++) begin
				ram_wmask[b*8 +: 8] = {8{be_ok[b]}};
			end
			if (ECC_EN != 0 && be_ok == 4'hF) begin
				ram_wmask[LBR_RW-1:LBR_DW] = '1;
			end
		end
	end

	lbr_ram #(.DEPTH_LOG2(DEPTH_LOG2), .WIDTH(LBR_RW)) u_ram (
		.core_clk(core_clk),
		.en(ram_en),
		.addr(ram_addr),
		.wdata(ram_wdata),
		.wmask(ram_wmask),
		.rdata(ram_rdata)
	);

	// Partial write capture, second cycle writes merged word
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rmw_q <= 1'b0;
			rmw_be_q <= 4'h0;
			rmw_data_q <= '0;
			rmw_addr_q <= '0;
			rmw_port_q <= '0;
		end else begin
			rmw_q <= partial && !rmw_q;
			rmw_be_q <= be_ok;
			rmw_data_q <= win.wdata;
			rmw_addr_q <= win.addr[DEPTH_LOG2+1:2];
			rmw_port_q <= win_idx;
		end
	end

	// Read tracking
	logic rd_q;
	logic [PW-1:0] rd_port_q;
	logic [31:0] rd_addr_q;
	logic ack_q;
	logic [PW-1:0] ack_port_q;
	logic ev_ce;
	logic ev_ue;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rd_q <= 1'b0;
			rd_port_q <= '0;
			rd_addr_q <= '0;
			ack_q <= 1'b0;
			ack_port_q <= '0;
		end else begin
			rd_q <= win_any && win.read_strobe && !rmw_q;
			rd_port_q <= win_idx;
			rd_addr_q <= win.addr;
			ack_q <= win_any && !partial && !rmw_q;
			ack_port_q <= rmw_q ? rmw_port_q : win_idx;
		end
	end

	assign ev_ce = rd_q && chk_on && dec_ce;
	assign ev_ue = rd_q && chk_on && dec_ue;

	// Ready and error flags routed to the requesting port; read data goes to every port
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			bus_rsp[p].rdata = chk_on ? fixed : ram_rdata[LBR_DW-1:0];
			bus_rsp[p].ready = (ack_q && ack_port_q == PW'(p))
				|| (rmw_q && rmw_port_q == PW'(p));
			bus_rsp[p].ce = ev_ce && rd_port_q == PW'(p);
			bus_rsp[p].ue = ev_ue && rd_port_q == PW'(p);
		end
	end

	// Error status and first failing addresses
	logic [1:0] status_q;
	logic [31:0] ce_addr_q;
	logic [31:0] ue_addr_q;
	logic [CNW-1:0] ce_cnt_q;
	logic st_wr;
	assign st_wr = HAS_REGS && reg_req.wr && reg_req.addr == LBR_REG_STATUS;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			status_q <= 2'h0;
		end else begin
			for (int b = 0; b < 2; b++) begin
				if ((b == LBR_ST_CE) ? ev_ce : ev_ue) begin
					status_q[b] <= 1'b1; // Set wins over clear
				end else if (st_wr && reg_req.wdata[b]) begin
					status_q[b] <= 1'b0;
				end
			end
		end
	end

	// Capture only while the matching status bit is clear
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ce_addr_q <= '0;
			ue_addr_q <= '0;
		end else begin
			if (CE_CAPTURE != 0 && ev_ce && !status_q[LBR_ST_CE]) begin
				ce_addr_q <= rd_addr_q;
			end
			if (UE_CAPTURE != 0 && ev_ue && !status_q[LBR_ST_UE]) begin
				ue_addr_q <= rd_addr_q;
			end
		end
	end

	// Saturating correctable counter, software writable
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ce_cnt_q <= '0;
		end else if (CE_COUNTER_WIDTH != 0) begin
			if (ev_ce && ce_cnt_q != '1) begin
				ce_cnt_q <= ce_cnt_q + CNW'(1);
			end else if (HAS_REGS && reg_req.wr
				&& reg_req.addr == LBR_REG_CE_CNT) begin
				ce_cnt_q <= reg_req.wdata[CNW-1:0];
			end
		end
	end

	// Software-written control registers
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			onoff_q <= CHECK_ENABLE_RESET_VALUE;
			ctrl_q <= LBR_CTRL_RST;
			inj_data_q <= '0;
			inj_chk_q <= '0;
		end else if (HAS_REGS && reg_req.wr) begin
			unique case (reg_req.addr)
				LBR_REG_ONOFF: if (ONOFF_EN != 0) begin
					onoff_q <= reg_req.wdata[0];
				end
				LBR_REG_CTRL: if (STATUS_EN != 0) begin
					ctrl_q <= reg_req.wdata;
				end
				LBR_REG_INJ_DATA: if (FAULT_INJECT != 0) begin
					inj_data_q <= reg_req.wdata;
				end
				LBR_REG_INJ_CHK: if (FAULT_INJECT != 0) begin
					inj_chk_q <= reg_req.wdata[LBR_CW-1:0];
				end
				default: ;
			endcase
		end
	end

	// Register read data, one cycle after the strobe
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else if (HAS_REGS && reg_req.rd) begin
			unique case (reg_req.addr)
				LBR_REG_STATUS: reg_rdata <= {30'h0, status_q};
				LBR_REG_CTRL: reg_rdata <= ctrl_q;
				LBR_REG_ONOFF: reg_rdata <= {31'h0, onoff_q};
				LBR_REG_CE_ADDR: reg_rdata <= ce_addr_q;
				LBR_REG_UE_ADDR: reg_rdata <= ue_addr_q;
				LBR_REG_CE_CNT: reg_rdata <= 32'(ce_cnt_q);
				LBR_REG_INJ_DATA: reg_rdata <= inj_data_q;
				LBR_REG_INJ_CHK: reg_rdata <= 32'(inj_chk_q);
				default: reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end
endmodule

// file: lbr_pkg.sv
// Purpose: shared constants and types for the block RAM controller
// Assumes: 32-bit memory bus, one clock
// Notes: register port offsets are word indices of a plain port
package lbr_pkg;

	localparam int unsigned LBR_AW = 32;
	localparam int unsigned LBR_DW = 32;
	localparam int unsigned LBR_CW = 7;
	localparam int unsigned LBR_RW = LBR_DW + LBR_CW;

	// Write access settings
	localparam logic [1:0] LBR_WR_NONE = 2'h0;
	localparam logic [1:0] LBR_WR_WORD = 2'h1;
	localparam logic [1:0] LBR_WR_FULL = 2'h2;

	// Defaults
	localparam logic [31:0] LBR_MASK_RST = 32'h00800000;
	localparam logic [31:0] LBR_BASE_RST = 32'h00000000;
	localparam logic [31:0] LBR_TOP_RST = 32'h00001FFF;

	// Register port offsets
	localparam logic [3:0] LBR_REG_STATUS = 4'h0;
	localparam logic [3:0] LBR_REG_CTRL = 4'h1;
	localparam logic [3:0] LBR_REG_ONOFF = 4'h2;
	localparam logic [3:0] LBR_REG_CE_ADDR = 4'h3;
	localparam logic [3:0] LBR_REG_UE_ADDR = 4'h4;
	localparam logic [3:0] LBR_REG_CE_CNT = 4'h5;
	localparam logic [3:0] LBR_REG_INJ_DATA = 4'h6;
	localparam logic [3:0] LBR_REG_INJ_CHK = 4'h7;

	// Status bit positions
	localparam int unsigned LBR_ST_CE = 0;
	localparam int unsigned LBR_ST_UE = 1;
	// Control bit: check-bit generation enable
	localparam int unsigned LBR_CT_GEN = 0;
	localparam logic [31:0] LBR_CTRL_RST = 32'h00000001;

	// One memory bus request
	typedef struct packed {
		logic [LBR_AW-1:0] addr;
		logic [LBR_DW-1:0] wdata;
		logic [3:0] be;
		logic addr_strobe;
		logic read_strobe;
		logic write_strobe;
	} lbr_req_t;

	// One memory bus answer
	typedef struct packed {
		logic [LBR_DW-1:0] rdata;
		logic ready;
		logic ce;
		logic ue;
	} lbr_rsp_t;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} lbr_reg_t;

endpackage

// file: lbr_ram.sv
// Purpose: block RAM with byte-lane writes and registered read
// Assumes: one port, one clock
// Notes: check bits sit above the data lanes
`timescale 1ns/10ps
module lbr_ram #(
	parameter int unsigned DEPTH_LOG2 = 11,
	parameter int unsigned WIDTH = 39
) (
	// Clock
	input wire logic core_clk,
	// Access
	input wire logic en,
	input wire logic [DEPTH_LOG2-1:0] addr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [WIDTH-1:0] wmask,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [0:(1<<DEPTH_LOG2)-1];

	// Masked write and registered read
	always_ff @(posedge core_clk) begin
		if (en) begin
			mem[addr] <= (mem[addr] & ~wmask) | (wdata & wmask);
			rdata <= mem[addr];
		end
	end
endmodule

// file: lbr_ecc.sv
// Purpose: Hamming SEC-DED check bits and syndrome decode
// Assumes: 32 data bits, 7 check bits
// Notes: purely combinational
`timescale 1ns/10ps
module lbr_ecc
	import lbr_pkg::*;
(
	// Encode
	input wire logic [LBR_DW-1:0] enc_data,
	output logic [LBR_CW-1:0] enc_chk,
	// Decode
	input wire logic [LBR_DW-1:0] dec_data,
	input wire logic [LBR_CW-1:0] dec_chk,
	output logic [LBR_DW-1:0] dec_fixed,
	output logic dec_ce,
	output logic dec_ue
);
	// Code position of a data bit; powers of two stay free for check bits
	function automatic logic [5:0] pos_of(input int i);
		return 6'(i + 3 + ((i >= 1) ? 1 : 0) + ((i >= 4) ? 1 : 0)
			+ ((i >= 11) ? 1 : 0) + ((i >= 26) ? 1 : 0));
	endfunction

	// Check bits: six Hamming parities over position codes, plus overall
	function automatic logic [LBR_CW-1:0] chk_of(input logic [LBR_DW-1:0] d);
		logic [LBR_CW-1:0] c;
		logic [5:0] pos;
		c = '0;
		for (int i = 0; i < LBR_DW; i++) begin
			pos = pos_of(i);
			for (int b = 0; b < 6; b++) begin
				c[b] = c[b] ^ (d[i] & pos[b]);
			end
		end
		c[6] = ^{d, c[5:0]};
		return c;
	endfunction

	logic [LBR_CW-1:0] syn;
	logic odd;

	assign enc_chk = chk_of(enc_data);
	assign syn = chk_of(dec_data) ^ dec_chk;
	// Parity over every stored bit; odd means exactly one flip
	assign odd = ^syn;

	// Correct the single flipped data bit, flag double errors
	always_comb begin
		dec_fixed = dec_data;
		for (int i = 0; i < LBR_DW; i++) begin
			if (odd && syn[5:0] == pos_of(i)) begin
				dec_fixed[i] = ~dec_data[i];
			end
		end
		dec_ce = odd;
		dec_ue = !odd && (syn[5:0] != 6'h00);
	end
endmodule

// file: lbr_ctrl_monitor.sv
// Purpose: port-level checks of the block RAM controller
// Assumes: masters wait for ready before the next request
// Notes: port 0 carries most checks, port 1 the arbitration ones
`timescale 1ns/10ps
module lbr_ctrl_monitor
	import lbr_pkg::*;
#(
	parameter int unsigned NUM_PORTS = 1,
	parameter logic [31:0] WINDOW_BASE = LBR_BASE_RST,
	parameter logic [31:0] DECODE_MASK [NUM_PORTS] = '{default: LBR_MASK_RST}
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Memory bus ports
	input wire lbr_pkg::lbr_req_t bus_req [NUM_PORTS],
	input wire lbr_pkg::lbr_rsp_t bus_rsp [NUM_PORTS],
	// Register port
	input wire lbr_pkg::lbr_reg_t reg_req,
	input wire logic [31:0] reg_rdata
);
	logic hit0;
	logic hit1;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// Window match per port, masked bits only
	assign hit0 = bus_req[0].addr_strobe && ((bus_req[0].addr & DECODE_MASK[0])
		== (WINDOW_BASE & DECODE_MASK[0]));
	assign hit1 = bus_req[NUM_PORTS-1].addr_strobe
		&& ((bus_req[NUM_PORTS-1].addr & DECODE_MASK[NUM_PORTS-1])
		== (WINDOW_BASE & DECODE_MASK[NUM_PORTS-1]));
	a_hit_ready: assert property (hit0 && bus_req[0].read_strobe |=>
		bus_rsp[0].ready) else $error("read hit without ready");
	a_miss_silent: assert property (bus_req[0].addr_strobe && !hit0
		|=> !bus_rsp[0].ready) else $error("ready on a miss");
	a_lose_collision: assert property (hit0 && hit1 && NUM_PORTS > 1
		|=> !bus_rsp[NUM_PORTS-1].ready) else $error("loser got ready");
	a_port1_ready: assert property (hit1 && !hit0
		&& bus_req[NUM_PORTS-1].read_strobe |=> bus_rsp[NUM_PORTS-1].ready)
		else $error("port 1 read without ready");
	a_flags_excl: assert property (!(bus_rsp[0].ce && bus_rsp[0].ue))
		else $error("ce and ue together");
	a_flag_ready: assert property (bus_rsp[0].ce || bus_rsp[0].ue |->
		bus_rsp[0].ready) else $error("error flag without ready");
	a_ready_cause: assert property (bus_rsp[0].ready |->
		$past(bus_req[0].addr_strobe) || $past(bus_req[0].addr_strobe, 2))
		else $error("ready without request");
	a_word_ack: assert property (hit0 && bus_req[0].write_strobe
		&& bus_req[0].be == 4'hF |=> bus_rsp[0].ready)
		else $error("word write without ready");
	a_reg_quiet: assert property (!$past(reg_req.rd) |->
		reg_rdata == 32'h0) else $error("register data outside read");
endmodule

// file: lbr_master.sv
// Purpose: bus master model for one memory bus port
// Assumes: ready arrives within three cycles
// Notes: released address and data are inverted, never left stale
`timescale 1ns/10ps
module lbr_master
	import lbr_pkg::*;
(
	// Clock
	input wire logic core_clk,
	// Bus
	output lbr_pkg::lbr_req_t req,
	input wire lbr_pkg::lbr_rsp_t rsp
);
	// Idle bus at time zero
	initial begin
		req = '0;
	end
	// One transfer; ok stays low if no ready came
	task automatic xfer(input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] be, input logic wr, output lbr_rsp_t r,
		output logic ok);
		ok = 1'b0;
		r = '0;
		@(posedge core_clk);
		req.addr <= a;
		req.wdata <= d;
		req.be <= be;
		req.addr_strobe <= 1'b1;
		req.read_strobe <= !wr;
		req.write_strobe <= wr;
		@(posedge core_clk);
		req.addr_strobe <= 1'b0;
		req.read_strobe <= 1'b0;
		req.write_strobe <= 1'b0;
		for (int n = 0; n < 3 && !ok; n++) begin
			@(negedge core_clk);
			if (rsp.ready === 1'b1) begin
				ok = 1'b1;
				r = rsp;
			end
		end
		@(posedge core_clk);
		req.addr <= ~req.addr;
		req.wdata <= ~req.wdata;
	endtask
endmodule

// file: lbr_ctrl_tb_top.sv
// Purpose: self-checking bench of the block RAM controller
// Assumes: two ports, ECC and all register features on; a second
// controller with word-only writes and no ECC
// Notes: 16-word RAM, masks compare address bit 23 only
`timescale 1ns/10ps
module lbr_ctrl_tb_top;
	import lbr_pkg::*;
	logic core_clk;
	logic rstn;
	lbr_req_t req [2];
	lbr_rsp_t rsp [2];
	lbr_reg_t reg_req;
	logic [31:0] reg_rdata;
	lbr_rsp_t r;
	lbr_rsp_t r1;
	logic ok;
	logic ok1;
	logic [31:0] v;
	int n_mismatch = 0;
	int compares = 0;
	// Feature switch of the full controller; RAM size shared by both controllers
	localparam int unsigned FEAT = 1;
	localparam int unsigned DEPTH = 4;
	lbr_req_t req2 [1];
	lbr_rsp_t rsp2 [1];
	logic [31:0] reg_rdata2;
	// Full-featured controller, default masks on both ports
	lbr_ctrl #(.NUM_PORTS(2), .ECC_EN(FEAT), .REG_PORT_EN(FEAT),
		.FAULT_INJECT(FEAT), .CE_CAPTURE(FEAT), .UE_CAPTURE(FEAT),
		.STATUS_EN(FEAT), .ONOFF_EN(FEAT), .CE_COUNTER_WIDTH(4),
		.DEPTH_LOG2(DEPTH)) dut (.core_clk(core_clk), .rstn(rstn),
		.bus_req(req), .bus_rsp(rsp), .reg_req(reg_req),
		.reg_rdata(reg_rdata));
	// Plain controller: word-only writes, no ECC, no registers
	lbr_ctrl #(.WRITE_ACCESS(LBR_WR_WORD), .DEPTH_LOG2(DEPTH)) dut_word (
		.core_clk(core_clk), .rstn(rstn), .bus_req(req2),
		.bus_rsp(rsp2), .reg_req(reg_req), .reg_rdata(reg_rdata2));
	lbr_master m0 (.core_clk(core_clk), .req(req[0]), .rsp(rsp[0]));
	lbr_master m1 (.core_clk(core_clk), .req(req[1]), .rsp(rsp[1]));
	lbr_master m2 (.core_clk(core_clk), .req(req2[0]), .rsp(rsp2[0]));
	// 40 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic end_sim();
		$display("Mismatches %0d, compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			$display("Error at %0t: got %h expected %h", $time, g, e);
			n_mismatch++;
		end
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		reg_req.wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		reg_req.rd <= 1'b0;
		@(negedge core_clk);
		chk(reg_rdata, e);
	endtask
	task automatic bus_wr(input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] be);
		m0.xfer(a, d, be, 1'b1, r, ok);
		chk({31'h0, ok}, 32'h1);
	endtask
	task automatic bus_rd(input logic [31:0] a, input logic [31:0] e,
		input logic ce, input logic ue);
		m0.xfer(a, 32'h0, 4'hF, 1'b0, r, ok);
		chk({29'h0, ok, r.ce, r.ue}, {29'h0, 1'b1, ce, ue});
		chk(r.rdata, e);
	endtask
	// Reset values and an unmapped index
	task automatic t_reset();
		reg_rd(LBR_REG_ONOFF, 32'h1);
		reg_rd(LBR_REG_CTRL, LBR_CTRL_RST);
		reg_rd(4'h8, 32'h0);
	endtask
	// Plain traffic, lanes, aliasing, second port, miss, collision
	task automatic t_basic();
		bus_wr(32'h8, 32'hA5A51234, 4'hF);
		bus_wr(32'h8, 32'h00007700, 4'h2);
		bus_rd(32'h48, 32'hA5A57734, 1'b0, 1'b0);
		m1.xfer(32'h8, 32'h0, 4'hF, 1'b0, r1, ok1);
		chk(r1.rdata, 32'hA5A57734);
		m0.xfer(32'h00800008, 32'h0, 4'hF, 1'b0, r, ok);
		chk({31'h0, ok}, 32'h0);
		fork
			m0.xfer(32'h8, 32'h0, 4'hF, 1'b0, r, ok);
			m1.xfer(32'h8, 32'h0, 4'hF, 1'b0, r1, ok1);
		join
		chk({30'h0, ok, ok1}, 32'h2);
	endtask
	// Injected single and double errors, capture, count, status
	task automatic t_ecc();
		reg_wr(LBR_REG_INJ_DATA, 32'h20);
		bus_wr(32'h10, 32'hCAFE0001, 4'hF);
		reg_wr(LBR_REG_INJ_DATA, 32'h1);
		bus_wr(32'h14, 32'h5, 4'hF);
		reg_wr(LBR_REG_INJ_DATA, 32'h3);
		bus_wr(32'h18, 32'h77, 4'hF);
		reg_wr(LBR_REG_INJ_DATA, 32'h0);
		reg_wr(LBR_REG_INJ_CHK, 32'h1);
		bus_wr(32'h20, 32'h00C0FFEE, 4'hF);
		reg_wr(LBR_REG_INJ_CHK, 32'h0);
		bus_rd(32'h10, 32'hCAFE0001, 1'b1, 1'b0);
		bus_rd(32'h14, 32'h5, 1'b1, 1'b0);
		reg_rd(LBR_REG_CE_ADDR, 32'h10);
		reg_rd(LBR_REG_CE_CNT, 32'h2);
		m0.xfer(32'h18, 32'h0, 4'hF, 1'b0, r, ok);
		chk({29'h0, ok, r.ce, r.ue}, 32'h5);
		reg_rd(LBR_REG_UE_ADDR, 32'h18);
		reg_rd(LBR_REG_STATUS, 32'h3);
		reg_wr(LBR_REG_CTRL, 32'h0);
		bus_wr(32'h1C, 32'h1, 4'hF);
		reg_wr(LBR_REG_CTRL, 32'h1);
		m0.xfer(32'h1C, 32'h0, 4'hF, 1'b0, r, ok);
		chk({30'h0, ok, r.ce | r.ue}, 32'h3);
	endtask
	// Checking switched off and back on
	task automatic t_off();
		reg_wr(LBR_REG_STATUS, 32'h3);
		reg_rd(LBR_REG_STATUS, 32'h0);
		reg_wr(LBR_REG_CE_CNT, 32'h0);
		reg_wr(LBR_REG_ONOFF, 32'h0);
		bus_rd(32'h10, 32'hCAFE0021, 1'b0, 1'b0);
		reg_rd(LBR_REG_CE_CNT, 32'h0);
		reg_wr(LBR_REG_ONOFF, 32'h1);
		bus_rd(32'h20, 32'h00C0FFEE, 1'b1, 1'b0);
		reg_rd(LBR_REG_CE_ADDR, 32'h20);
		bus_rd(32'h10, 32'hCAFE0001, 1'b1, 1'b0);
		reg_rd(LBR_REG_CE_CNT, 32'h2);
	endtask
	// Partial writes refused but answered under word-only access; no registers without ECC
	task automatic t_access();
		m2.xfer(32'h4, 32'h12345678, 4'hF, 1'b1, r, ok);
		chk({31'h0, ok}, 32'h1);
		m2.xfer(32'h4, 32'h000000FF, 4'h1, 1'b1, r, ok);
		chk({31'h0, ok}, 32'h1);
		m2.xfer(32'h4, 32'h0, 4'hF, 1'b0, r, ok);
		chk(r.rdata, 32'h12345678);
		reg_rd(LBR_REG_ONOFF, 32'h1);
		chk(reg_rdata2, 32'h0);
	endtask
	// Main sequence
	initial begin
		rstn = 1'b0;
		reg_req = '0;
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		t_reset();
		t_basic();
		t_ecc();
		t_off();
		t_access();
		end_sim();
	end
	// Hang guard
	initial begin
		#1000000;
		n_mismatch++;
		end_sim();
	end
endmodule
bind lbr_ctrl lbr_ctrl_monitor #(.NUM_PORTS(NUM_PORTS),
	.WINDOW_BASE(WINDOW_BASE), .DECODE_MASK(DECODE_MASK)) mon (
	.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req),
	.bus_rsp(bus_rsp), .reg_req(reg_req), .reg_rdata(reg_rdata));
